/* File: multi_sensor_stream_sync.sv */
// daisy-chain start synchroniser for one sensor node
// assumes a common clock on all nodes and register writes from the serial slave
`timescale 1ns/1ps
`include "stream_sync_defs.svh"
module multi_sensor_stream_sync
    import stream_sync_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    input  wire logic        saddr_pin_in,
    input  wire logic        chain_pin_in,
    output logic             chain_pin_out,
    output logic             chain_pin_oe_out,
    input  wire logic        stream_req_in,
    output logic             stream_go_out,
    output logic      [6:0]  slave_addr_out
);

    // register file
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] pad_r;
    logic [15:0] pad_nxt;
    logic [6:0]  addr_r;
    logic [6:0]  addr_nxt;
    logic        addr_set_r;
    logic        addr_set_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;

    // chain and start state
    start_state_e state_r;
    start_state_e state_nxt;
    logic         chain_r;
    logic         chain_nxt;
    logic         go_r;
    logic         go_nxt;
    logic [6:0]   sel_addr_r;
    logic [6:0]   sel_addr_nxt;

    logic      saddr_lvl;
    logic      saddr_prev;
    logic      evt;
    logic      link_en;
    logic      sync_en;
    logic      is_master;
    logic      pad_oe;
    position_t pos;
    delay_t    wait_cnt;
    logic      wr_ctrl;
    logic      wr_pad;
    logic      wr_addr;

    delay_link_if tl ();

    pin_sync2 u_saddr_sync (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (saddr_pin_in),
        .level_out (saddr_lvl),
        .prev_out  (saddr_prev)
    );

    delay_timer u_delay (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .lnk      (tl.tmr)
    );

    assign link_en   = ctrl_r[`LINK_EN_BIT];
    assign sync_en   = ctrl_r[`SYNC_EN_BIT];
    assign is_master = ctrl_r[`MASTER_BIT];
    assign pos       = ctrl_r[`POS_MSB:`POS_LSB];
    assign pad_oe    = pad_r[`PAD_CHAIN_OE_BIT];

    // an event is the rising edge of a high pulse on the otherwise low address-select line
    assign evt = saddr_lvl && !saddr_prev;

    // hop latency is one forwarding flop plus two synchroniser flops
    assign wait_cnt = 6'(`HOP_CYCLES * {2'h0, pos}) + `DELAY_BIAS;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == `LINK_CTRL_ADDR);
    assign wr_pad  = reg_wr_in && (reg_addr_in == `PAD_CTRL_ADDR);
    assign wr_addr = reg_wr_in && (reg_addr_in == `SLAVE_ADDR_ADDR);

    // register writes and reads
    always_comb begin
        ctrl_nxt     = ctrl_r;
        pad_nxt      = pad_r;
        addr_nxt     = addr_r;
        addr_set_nxt = addr_set_r;
        rdata_nxt    = rdata_r;
        rvalid_nxt   = 1'b0;
        if (wr_ctrl) begin
            ctrl_nxt = reg_wdata_in & `LINK_CTRL_WMASK;
        end
        if (wr_pad) begin
            pad_nxt = reg_wdata_in;
        end
        if (wr_addr) begin
            addr_nxt     = reg_wdata_in[`SLAVE_ADDR_MSB:`SLAVE_ADDR_LSB];
            addr_set_nxt = 1'b1;
        end
        if (reg_rd_in) begin
            rvalid_nxt = 1'b1;
            unique case (reg_addr_in)
                `LINK_CTRL_ADDR:  rdata_nxt = ctrl_r;
                `PAD_CTRL_ADDR:   rdata_nxt = pad_r;
                `SLAVE_ADDR_ADDR: rdata_nxt = {8'h00, sel_addr_r, 1'b0};
                default:          rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ctrl_r     <= `LINK_CTRL_RST;
            pad_r      <= `PAD_CTRL_RST;
            addr_r     <= 7'h00;
            addr_set_r <= 1'b0;
            rdata_r    <= 16'h0000;
            rvalid_r   <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            pad_r      <= pad_nxt;
            addr_r     <= addr_nxt;
            addr_set_r <= addr_set_nxt;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rvalid_nxt;
        end
    end

    // start sequencing, forwarding and address choice
    always_comb begin
        state_nxt = state_r;
        chain_nxt = 1'b0;
        tl.load   = 1'b0;
        tl.count  = wait_cnt;
        // the pin level selects the default address until one is assigned
        if (addr_set_r) begin
            sel_addr_nxt = addr_r;
        end else if (saddr_lvl) begin
            sel_addr_nxt = `DEFAULT_ADDR_HIGH;
        end else begin
            sel_addr_nxt = `DEFAULT_ADDR_LOW;
        end
        if (link_en && !is_master && evt) begin
            chain_nxt = 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (stream_req_in) begin
                    if (!(link_en && sync_en)) begin
                        state_nxt = ST_RUN;
                    end else if (is_master) begin
                        chain_nxt = 1'b1;
                        tl.load   = 1'b1;
                        state_nxt = ST_DELAY;
                    end else begin
                        state_nxt = ST_ARMED;
                    end
                end
            end
            ST_ARMED: begin
                if (evt) begin
                    tl.load   = 1'b1;
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (tl.done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
        endcase
        if (!stream_req_in) begin
            state_nxt = ST_IDLE;
        end
        go_nxt = (state_nxt == ST_RUN);
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_r    <= ST_IDLE;
            chain_r    <= 1'b0;
            go_r       <= 1'b0;
            sel_addr_r <= `DEFAULT_ADDR_LOW;
        end else begin
            state_r    <= state_nxt;
            chain_r    <= chain_nxt;
            go_r       <= go_nxt;
            sel_addr_r <= sel_addr_nxt;
        end
    end

    assign reg_rdata_out    = rdata_r;
    assign reg_rvalid_out   = rvalid_r;
    // pad stays an input until enabled, then idles low
    assign chain_pin_oe_out = pad_oe;
    assign chain_pin_out    = pad_oe && chain_r;
    assign stream_go_out    = go_r;
    assign slave_addr_out   = sel_addr_r;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_ctrl_reset_zero: assert property (
        $past(!rst_n_in) |-> (ctrl_r == 16'h0000) && !chain_pin_oe_out)
        else $error("control or pad state not cleared by reset");

    a_pad_drive_low: assert property (
        $rose(chain_pin_oe_out) |-> !chain_pin_out)
        else $error("chain pin not low when output first enabled");

    a_default_addr: assert property (
        (!$past(addr_set_r) && !addr_set_r && $past(rst_n_in))
        |-> slave_addr_out == ($past(saddr_lvl) ? `DEFAULT_ADDR_HIGH : `DEFAULT_ADDR_LOW))
        else $error("default address does not follow address select");

    a_addr_replace: assert property (
        wr_addr |-> ##2 slave_addr_out == $past(reg_wdata_in[7:1], 2))
        else $error("written slave address not answered two cycles later");

    a_forward_event: assert property (
        (link_en && !is_master && pad_oe && evt) ##1 pad_oe |-> chain_pin_out ##1 !chain_pin_out)
        else $error("upstream event not forwarded as one pulse");

    a_master_emit: assert property (
        (state_r == ST_IDLE && stream_req_in && link_en && sync_en && is_master && pad_oe)
        ##1 pad_oe |-> chain_pin_out && !stream_go_out)
        else $error("master did not emit event on stream start");

    a_slave_hold: assert property (
        (state_r == ST_ARMED && !evt) |=> !stream_go_out)
        else $error("slave streaming before upstream event");

    a_delay_count: assert property (
        (state_r == ST_ARMED && evt && stream_req_in) |-> tl.load && tl.count == wait_cnt
        ##1 state_r == ST_DELAY)
        else $error("slave delay not loaded from position");

    a_go_after_delay: assert property (
        (state_r == ST_DELAY && tl.done && stream_req_in) |=> stream_go_out && state_r == ST_RUN)
        else $error("streaming did not start when delay expired");

    a_go_waits_delay: assert property (
        (state_r == ST_DELAY && !tl.done) |=> !stream_go_out)
        else $error("streaming started before delay expired");

    a_stop_clears: assert property (
        !stream_req_in |=> !stream_go_out && state_r == ST_IDLE)
        else $error("streaming not stopped on request low");

    a_read_answer: assert property (
        (reg_rd_in && reg_addr_in == `LINK_CTRL_ADDR && !wr_ctrl) |=> reg_rvalid_out
        && reg_rdata_out == $past(ctrl_r))
        else $error("control register read mismatch");

    a_plain_start: assert property (
        (state_r == ST_IDLE && stream_req_in && !(link_en && sync_en)) |=> stream_go_out)
        else $error("unsynchronised start not immediate");

endmodule // multi_sensor_stream_sync

/* File: stream_sync_defs.svh */
// register offsets, field positions, reset values and timing counts
// assumes 16-bit register addresses and data on the control port
`ifndef STREAM_SYNC_DEFS_SVH
`define STREAM_SYNC_DEFS_SVH

`define LINK_CTRL_ADDR      16'h31fc
`define SLAVE_ADDR_ADDR     16'h002e
`define PAD_CTRL_ADDR       16'h0032

`define LINK_EN_BIT         15
`define SYNC_EN_BIT         14
`define MASTER_BIT          13
`define POS_MSB             11
`define POS_LSB             8
`define LINK_CTRL_RST       16'h0000
`define LINK_CTRL_WMASK     16'hef00

`define PAD_CHAIN_OE_BIT    0
`define PAD_CTRL_RST        16'h0000

`define SLAVE_ADDR_MSB      7
`define SLAVE_ADDR_LSB      1
`define DEFAULT_ADDR_LOW    7'h48
`define DEFAULT_ADDR_HIGH   7'h5d

`define HOP_CYCLES          6'h03
`define DELAY_BIAS          6'h01

`endif

/* File: stream_sync_pkg.sv */
// types shared by the chain start logic
// assumes stream_sync_defs.svh for the numeric constants
package stream_sync_pkg;

    typedef logic [5:0] delay_t;
    typedef logic [3:0] position_t;

    // gray codes along idle -> armed -> delay -> run
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ARMED = 2'h1,
        ST_DELAY = 2'h3,
        ST_RUN   = 2'h2
    } start_state_e;

endpackage

/* File: delay_link_if.sv */
// carrier between the start controller and its delay timer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface delay_link_if;
    import stream_sync_pkg::*;

    logic   load;
    delay_t count;
    logic   done;

    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

/* File: pin_sync2.sv */
// two-stage synchroniser for one pin, with a third stage for edge use
// assumes the pin is asynchronous to mclk_in
`timescale 1ns/1ps
module pin_sync2 (
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      prev_out
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;

    always_comb begin
        stage_nxt = {stage_r[1:0], pin_in};
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            stage_r <= 3'h0;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign level_out = stage_r[1];
    assign prev_out  = stage_r[2];

    a_sync_two_stage: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ($past(rst_n_in, 1) && $past(rst_n_in, 2)) |-> level_out == $past(pin_in, 2))
        else $error("synchroniser output does not trail pin by two cycles");
endmodule // pin_sync2

/* File: delay_timer.sv */
// down counter: done pulses exactly count cycles after load
// assumes count is at least one when loaded
`timescale 1ns/1ps
module delay_timer
    import stream_sync_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    delay_link_if.tmr lnk
);
    delay_t cnt_r;
    delay_t cnt_nxt;
    logic   busy_r;
    logic   busy_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        if (lnk.load) begin
            cnt_nxt  = lnk.count;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            cnt_nxt  = cnt_r - 6'h01;
            busy_nxt = (cnt_r != 6'h01);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cnt_r  <= 6'h00;
            busy_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign lnk.done = busy_r && (cnt_r == 6'h01) && !lnk.load;

    a_timer_three_hop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (lnk.load && lnk.count == 6'h04) ##1 !lnk.load [*4] |-> lnk.done && $past(!lnk.done, 1))
        else $error("timer loaded with four did not finish after four cycles");
endmodule // delay_timer

/* File: upstream_node_model.sv */
// upstream chain neighbour: drives the node's address-select line
// assumes the node's clock and reset; fire_in starts one chain event
`timescale 1ns/1ps
module upstream_node_model (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       drive_in,
    input  wire logic       fire_in,
    input  wire logic [3:0] pos_in,
    output logic            line_out,
    output logic            go_out
);
    logic       pulse_r;
    logic [5:0] cnt_r;

    // unconfigured neighbour holds the line high, configured one idles low
    assign line_out = drive_in ? pulse_r : 1'b1;

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pulse_r <= 1'b0;
            cnt_r   <= 6'h00;
            go_out  <= 1'b0;
        end else begin
            pulse_r <= fire_in;
            if (fire_in) begin
                go_out <= 1'b0;
            end
            // own start after its position-scaled wait
            if (pulse_r && pos_in == 4'h0) begin
                go_out <= 1'b1;
            end else if (pulse_r) begin
                cnt_r <= {2'h0, pos_in} * 6'h03;
            end else if (cnt_r != 6'h00) begin
                cnt_r <= cnt_r - 6'h01;
                if (cnt_r == 6'h01) begin
                    go_out <= 1'b1;
                end
            end
        end
    end
endmodule // upstream_node_model

/* File: tb.sv */
// register-level bench of one chain node with its upstream neighbour
// assumes inputs change 2 ns after the rising edge
`timescale 1ns/1ps
`include "stream_sync_defs.svh"
`define CHK(nm, ex, got) begin \
    checks++; \
    if ((got) !== (ex)) begin \
        num_errors++; \
        $display("BAD %s exp %h seen %h", nm, ex, got); \
    end \
end
module tb;
    logic        mclk_in       = 1'b0;
    logic        rst_n_in      = 1'b0;
    logic        reg_wr_in     = 1'b0;
    logic        reg_rd_in     = 1'b0;
    logic [15:0] reg_addr_in   = 16'h0000;
    logic [15:0] reg_wdata_in  = 16'h0000;
    logic        stream_req_in = 1'b0;
    logic        drive         = 1'b0;
    logic        fire          = 1'b0;
    logic [3:0]  up_pos        = 4'h2;
    logic [15:0] reg_rdata_out;
    logic        reg_rvalid_out;
    logic        saddr;
    logic        chain_pin_out;
    logic        chain_pin_oe_out;
    logic        stream_go_out;
    logic [6:0]  slave_addr_out;
    logic        up_go;
    wire         chain_wire = chain_pin_oe_out ? chain_pin_out : 1'b0;
    int          num_errors = 0;
    int          checks     = 0;

    always #12.5 mclk_in = ~mclk_in;

    multi_sensor_stream_sync multi_sensor_stream_sync_i (
        .mclk_in          (mclk_in),
        .rst_n_in         (rst_n_in),
        .reg_wr_in        (reg_wr_in),
        .reg_rd_in        (reg_rd_in),
        .reg_addr_in      (reg_addr_in),
        .reg_wdata_in     (reg_wdata_in),
        .reg_rdata_out    (reg_rdata_out),
        .reg_rvalid_out   (reg_rvalid_out),
        .saddr_pin_in     (saddr),
        .chain_pin_in     (chain_wire),
        .chain_pin_out    (chain_pin_out),
        .chain_pin_oe_out (chain_pin_oe_out),
        .stream_req_in    (stream_req_in),
        .stream_go_out    (stream_go_out),
        .slave_addr_out   (slave_addr_out)
    );

    upstream_node_model upstream_node_model_i (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .drive_in (drive),
        .fire_in  (fire),
        .pos_in   (up_pos),
        .line_out (saddr),
        .go_out   (up_go)
    );

    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #2;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        step(1);
        reg_wr_in    = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        step(1);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] ex);
        step(1);
        reg_rd_in   = 1'b1;
        reg_addr_in = a;
        step(1);
        reg_rd_in = 1'b0;
        `CHK("rvalid", 1'b1, reg_rvalid_out)
        `CHK("rdata", ex, reg_rdata_out)
    endtask

    // one upstream event; armed node must start with its neighbour
    task automatic run_fire(input logic armed);
        fire = 1'b1;
        for (int i = 0; i < 16; i++) begin
            step(1);
            fire = 1'b0;
            `CHK("forward", (i == 3), chain_pin_out)
            `CHK("go_align", armed ? up_go : 1'b0, stream_go_out)
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end

    initial begin
        step(10);
        rst_n_in = 1'b1;
        `CHK("oe_reset", 1'b0, chain_pin_oe_out)
        `CHK("chain_reset", 1'b0, chain_pin_out)
        step(3);
        `CHK("addr_high", 7'h5d, slave_addr_out)
        rd(`LINK_CTRL_ADDR, 16'h0000);
        rd(`PAD_CTRL_ADDR, 16'h0000);
        rd(16'h1234, 16'h0000);
        wr(`LINK_CTRL_ADDR, 16'hffff);
        rd(`LINK_CTRL_ADDR, 16'hef00);
        drive = 1'b1;
        step(4);
        `CHK("addr_low", 7'h48, slave_addr_out)
        wr(`SLAVE_ADDR_ADDR, 16'h00a4);
        step(2);
        `CHK("addr_new", 7'h52, slave_addr_out)
        drive = 1'b0;
        step(4);
        `CHK("addr_kept", 7'h52, slave_addr_out)
        wr(`LINK_CTRL_ADDR, 16'h0000);
        stream_req_in = 1'b1;
        step(2);
        `CHK("go_plain", 1'b1, stream_go_out)
        stream_req_in = 1'b0;
        step(2);
        `CHK("go_stop", 1'b0, stream_go_out)
        wr(`LINK_CTRL_ADDR, 16'he200);
        wr(`PAD_CTRL_ADDR, 16'h0001);
        step(1);
        `CHK("oe_on", 1'b1, chain_pin_oe_out)
        `CHK("chain_low", 1'b0, chain_pin_out)
        stream_req_in = 1'b1;
        for (int i = 1; i <= 12; i++) begin
            step(1);
            `CHK("master_event", (i == 1), chain_pin_out)
            `CHK("master_go", (i >= 8), stream_go_out)
        end
        stream_req_in = 1'b0;
        step(2);
        `CHK("master_stop", 1'b0, stream_go_out)
        rst_n_in = 1'b0;
        step(2);
        rst_n_in = 1'b1;
        drive    = 1'b1;
        step(3);
        wr(`SLAVE_ADDR_ADDR, 16'h00a6);
        wr(`PAD_CTRL_ADDR, 16'h0001);
        wr(`LINK_CTRL_ADDR, 16'hc100);
        run_fire(1'b0);
        stream_req_in = 1'b1;
        step(6);
        `CHK("slave_waits", 1'b0, stream_go_out)
        run_fire(1'b1);
        give_verdict();
    end
endmodule // tb
